// >>> olsc_top.sv
/*
 * Open-loop speed curve: maps a speed command duty onto an output PWM
 * duty, drives the output PWM, and limits how fast a target rotation
 * count may fall. Registers are reached over classic Wishbone.
 * Assumes the command arrives already quantised on a 1/512 scale and
 * that every input is synchronous to core_clk_i.
 */
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps

module olsc_top #(
	parameter int CMD_W   = 9,  // Command resolution in bits
	parameter int SPEED_W = 14  // Rotation count width
) (
	input  wire logic                        core_clk_i,
	input  wire logic                        rst_i,
	input  wire olsc_pkg::olsc_wb_req_type   wb_req_i,
	output logic                             wb_ack_o,
	output logic [31:0]                      wb_dat_o,
	input  wire logic [CMD_W:0]              speed_command_i,
	input  wire logic                        target_valid_i,
	input  wire logic [SPEED_W-1:0]          target_speed_i,
	output logic [SPEED_W-1:0]               applied_speed_o,
	output logic [9:0]                       out_duty_o,
	output logic                             pwm_o,
	output logic                             open_loop_active_o
);

	// ************************************************************
	// Declarations
	// ************************************************************
	olsc_pkg::olsc_cfg_type cfg_reg;              // All settings
	logic                   ack_reg;              // Bus answer pulse
	logic [31:0]            rdata_reg;            // Read data
	logic                   pass_reg;             // Pass-through engaged
	logic                   run_reg;              // Motor above start once
	logic [9:0]             cmd;                  // Saturated command
	logic [9:0]             start_d;              // Decoded start threshold
	logic [9:0]             stop_d;               // Decoded stop threshold
	logic [9:0]             max_d;                // Decoded max threshold
	logic [9:0]             hys_low;              // Pass-through release point
	logic [9:0]             max_out;              // Curve value at max threshold
	logic [9:0]             min_out;              // Minimum output duty
	logic [9:0]             duty_next;            // Curve result
	logic [9:0]             duty_reg;             // Applied output duty
	logic [9:0]             pwm_duty_reg;         // Duty latched per period
	logic [8:0]             pwm_cnt_reg;          // Output PWM position
	logic [15:0]            pwm_pre_reg;          // Step prescaler
	logic [SPEED_W-1:0]     speed_reg;            // Applied rotation count
	logic                   wr_en;                // Write commit
	logic [5:0]             idx;                  // Register index

	// ************************************************************
	// Functions
	// ************************************************************

	// Piecewise linear curve above the start threshold, saturated
	// Each segment product is scaled down on its own, so the two
	// truncations can cost one step at most against a single division.
	// Products are 24 bits wide: a 14-bit gain times a 10-bit span.
	function automatic logic [9:0] curve(input logic [9:0] c, input olsc_pkg::olsc_cfg_type k);
		logic [9:0]  st;
		logic [9:0]  chg;
		logic [23:0] p1;
		logic [23:0] p2;
		logic [16:0] sum;
		st  = {2'b00, k.start_threshold};
		chg = {1'b0, k.inflection_duty, 1'b0};
		p1  = 24'h000000;
		p2  = 24'h000000;
		if (c > st) begin
			if ((chg != 10'h000) && (c > chg) && (chg > st)) begin
				p1 = k.slope_one * (chg - st);
				p2 = k.slope_two * (c - chg);
			end else begin
				p1 = k.slope_one * (c - st);
			end
		end
		sum = {9'h000, k.min_output_level} + {3'b000, p1[23:10]} + {3'b000, p2[23:10]};
		if (sum > {7'h00, olsc_pkg::DUTY_FULL}) begin
			curve = olsc_pkg::DUTY_FULL;
		end else begin
			curve = sum[9:0];
		end
	endfunction

	// Fall limit lookup; zero code means no limit
	// The all-ones default lets any drop through in one update,
	// which is what the zero code asks for.
	function automatic logic [SPEED_W-1:0] fall_limit(input logic [2:0] sel);
		unique case (sel)
			3'h1:    fall_limit = SPEED_W'(olsc_pkg::FALL_LIM_1);
			3'h2:    fall_limit = SPEED_W'(olsc_pkg::FALL_LIM_2);
			3'h3:    fall_limit = SPEED_W'(olsc_pkg::FALL_LIM_3);
			3'h4:    fall_limit = SPEED_W'(olsc_pkg::FALL_LIM_4);
			3'h5:    fall_limit = SPEED_W'(olsc_pkg::FALL_LIM_5);
			3'h6:    fall_limit = SPEED_W'(olsc_pkg::FALL_LIM_6);
			3'h7:    fall_limit = SPEED_W'(olsc_pkg::FALL_LIM_7);
			default: fall_limit = '1;
		endcase
	endfunction

	// ************************************************************
	// Wishbone slave
	// ************************************************************
	assign idx   = wb_req_i.adr[7:2];
	// Writes land on the edge where the master samples ack
	// Upper byte lanes carry nothing, so only lane 0 gates a write.
	// A held strobe is answered every other cycle, never twice in a row.
	assign wr_en = ack_reg & wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & wb_req_i.sel[0];

	// Ack one cycle after the strobe, dropped the cycle after
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= wb_req_i.cyc & wb_req_i.stb & ~ack_reg;
		end
	end

	// Read mux; unmapped indices read as zero and still answer
	// Data is captured when a request is taken and holds until the next
	// one, so the master may sample it on the ack edge without a race.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_reg <= 32'h00000000;
		end else if (wb_req_i.cyc & wb_req_i.stb & ~ack_reg) begin
			unique case (idx)
				olsc_pkg::IDX_NO_STOP_BIT_STOP: rdata_reg <= {24'h000000, cfg_reg.no_stop_bit,
					cfg_reg.stop_threshold};
				olsc_pkg::IDX_START:      rdata_reg <= {24'h000000, cfg_reg.start_threshold};
				olsc_pkg::IDX_INFLECT:    rdata_reg <= {24'h000000, cfg_reg.inflection_duty};
				olsc_pkg::IDX_MAX:        rdata_reg <= {24'h000000, cfg_reg.max_threshold};
				olsc_pkg::IDX_MIN_OUT:    rdata_reg <= {24'h000000, cfg_reg.min_output_level};
				olsc_pkg::IDX_HYST:       rdata_reg <= {28'h0000000,
					cfg_reg.max_threshold_hysteresis};
				olsc_pkg::IDX_SLOPE1_LO:  rdata_reg <= {24'h000000, cfg_reg.slope_one[7:0]};
				olsc_pkg::IDX_SLOPE1_HI:  rdata_reg <= {24'h000000, cfg_reg.slope_one[13:8],
					cfg_reg.above_max_passthrough, cfg_reg.full_speed_at_off};
				olsc_pkg::IDX_SLOPE2_LO:  rdata_reg <= {24'h000000, cfg_reg.slope_two[7:0]};
				olsc_pkg::IDX_SLOPE2_HI:  rdata_reg <= {24'h000000, cfg_reg.slope_two[13:8],
					1'b0, cfg_reg.loop_mode_select};
				olsc_pkg::IDX_FALL_LIMIT: rdata_reg <= {24'h000000,
					cfg_reg.speed_fall_limit_sel, 5'h00};
				// Live state: duty, pass-through, run and loop flags
				olsc_pkg::IDX_STATUS:     rdata_reg <= {19'h00000, open_loop_active_o,
					run_reg, pass_reg, duty_reg};
				olsc_pkg::IDX_CMD_STATUS: rdata_reg <= {2'b00, speed_reg, 6'h00, cmd};
				default:                  rdata_reg <= 32'h00000000;
			endcase
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;

	// ************************************************************
	// Configuration registers
	// ************************************************************

	// Byte lane 0 only; the upper lanes hold nothing
	// Every field clears at reset: the block wakes in closed-loop mode
	// with the curve forced to zero until software enables it.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_reg <= '0;
		end else if (wr_en) begin
			unique case (idx)
				olsc_pkg::IDX_NO_STOP_BIT_STOP: begin
					cfg_reg.no_stop_bit    <= wb_req_i.dat[olsc_pkg::NO_STOP_BIT_BIT];
					cfg_reg.stop_threshold <= wb_req_i.dat[6:0];
				end
				olsc_pkg::IDX_START:     cfg_reg.start_threshold  <= wb_req_i.dat[7:0];
				olsc_pkg::IDX_INFLECT:   cfg_reg.inflection_duty  <= wb_req_i.dat[7:0];
				olsc_pkg::IDX_MAX:       cfg_reg.max_threshold    <= wb_req_i.dat[7:0];
				olsc_pkg::IDX_MIN_OUT:   cfg_reg.min_output_level <= wb_req_i.dat[7:0];
				olsc_pkg::IDX_HYST:      cfg_reg.max_threshold_hysteresis <= wb_req_i.dat[3:0];
				olsc_pkg::IDX_SLOPE1_LO: cfg_reg.slope_one[7:0]   <= wb_req_i.dat[7:0];
				olsc_pkg::IDX_SLOPE1_HI: begin
					cfg_reg.slope_one[13:8]       <= wb_req_i.dat[7:olsc_pkg::SLOPE_HI_LSB];
					cfg_reg.above_max_passthrough <= wb_req_i.dat[olsc_pkg::PASS_BIT];
					cfg_reg.full_speed_at_off     <= wb_req_i.dat[olsc_pkg::FSOFF_BIT];
				end
				olsc_pkg::IDX_SLOPE2_LO: cfg_reg.slope_two[7:0]   <= wb_req_i.dat[7:0];
				olsc_pkg::IDX_SLOPE2_HI: begin
					cfg_reg.slope_two[13:8]  <= wb_req_i.dat[7:olsc_pkg::SLOPE_HI_LSB];
					cfg_reg.loop_mode_select <= wb_req_i.dat[olsc_pkg::LOOP_BIT];
				end
				olsc_pkg::IDX_FALL_LIMIT:
					cfg_reg.speed_fall_limit_sel <= wb_req_i.dat[7:olsc_pkg::FALL_SEL_LSB];
				default: begin
				end
			endcase
		end
	end

	// ************************************************************
	// Threshold decode
	// ************************************************************

	// Command above full scale is clipped so the curve sees 0..512
	// Quantisation of analog or pulse-width commands happens upstream;
	// this block only sees the finished 1/512 value.
	assign cmd     = (10'(speed_command_i) > olsc_pkg::DUTY_FULL) ?
		olsc_pkg::DUTY_FULL : 10'(speed_command_i);
	assign start_d = {2'b00, cfg_reg.start_threshold};
	assign stop_d  = {2'b00, cfg_reg.stop_threshold, 1'b0};
	assign max_d   = {2'b00, cfg_reg.max_threshold} + olsc_pkg::MAX_OFFSET;
	// Release point sits (hys + 1) * 2 steps below max threshold
	assign hys_low = max_d - {4'h0, cfg_reg.max_threshold_hysteresis + 5'h01, 1'b0};
	assign min_out = {2'b00, cfg_reg.min_output_level};
	assign max_out = curve(max_d, cfg_reg);

	// ************************************************************
	// Curve state: pass-through and run memory
	// ************************************************************

	// Pass-through engages at max threshold, releases below the band
	// Without the band a command dithering on the threshold would make
	// the output jump between the curve end and the raw command.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pass_reg <= 1'b0;
		end else if (!cfg_reg.above_max_passthrough) begin
			pass_reg <= 1'b0;
		end else if (cmd >= max_d) begin
			pass_reg <= 1'b1;
		end else if (cmd < hys_low) begin
			pass_reg <= 1'b0;
		end
	end

	// Remembers a rising command crossed start; low band depends on it
	// This is what tells a falling command from a rising one inside the
	// stop-to-start band, where the two directions give different output while the no-stop bit is clear.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			run_reg <= 1'b0;
		end else if (cmd > start_d) begin
			run_reg <= 1'b1;
		end else if (cmd <= stop_d) begin
			run_reg <= 1'b0;
		end
	end

	// ************************************************************
	// Output duty selection
	// ************************************************************

	// Low-command cases first, then pass-through, then the curve
	// Pass-through lags the command by one cycle through its flag, so the
	// first cycle above max threshold still shows the curve end.
	always_comb begin
		duty_next = 10'h000;
		if (!cfg_reg.loop_mode_select) begin
			duty_next = 10'h000;
		end else if (cmd == 10'h000) begin
			if (cfg_reg.full_speed_at_off) begin
				duty_next = cfg_reg.above_max_passthrough ? olsc_pkg::DUTY_FULL : max_out;
			end else begin
				duty_next = cfg_reg.no_stop_bit ? min_out : 10'h000;
			end
		end else if (cmd <= stop_d) begin
			if (!cfg_reg.no_stop_bit) begin
				duty_next = 10'h000;
			end else if (cfg_reg.full_speed_at_off) begin
				duty_next = cfg_reg.above_max_passthrough ? olsc_pkg::DUTY_FULL : max_out;
			end else begin
				duty_next = min_out;
			end
		end else if (cmd <= start_d) begin
			// Zero while rising from stop, minimum once the motor ran
			duty_next = (cfg_reg.no_stop_bit || run_reg) ? min_out : 10'h000;
		end else if (pass_reg) begin
			duty_next = cmd;
		end else if (cmd >= max_d) begin
			duty_next = max_out;
		end else begin
			duty_next = curve(cmd, cfg_reg);
		end
	end

	// Registered result drives the PWM and the status view
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			duty_reg <= 10'h000;
		end else begin
			duty_reg <= duty_next;
		end
	end

	assign out_duty_o         = duty_reg;
	assign open_loop_active_o = cfg_reg.loop_mode_select;

	// ************************************************************
	// Output PWM
	// ************************************************************

	// Prescaled 9-bit counter; a slower step would trade rate for bits
	// The step count is rounded down, so the period runs slightly
	// faster than the nominal rate rather than slower.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pwm_pre_reg  <= 16'h0000;
			pwm_cnt_reg  <= 9'h000;
			pwm_duty_reg <= 10'h000;
		end else if (pwm_pre_reg == 16'(olsc_pkg::PWM_STEP_CYC - 1)) begin
			pwm_pre_reg <= 16'h0000;
			pwm_cnt_reg <= pwm_cnt_reg + 9'h001;
			// Duty taken only at period start so a pulse is never cut short
			if (pwm_cnt_reg == 9'h1ff) begin
				pwm_duty_reg <= duty_reg;
			end
		end else begin
			pwm_pre_reg <= pwm_pre_reg + 16'h0001;
		end
	end

	// Full scale keeps the output high for the whole period
	// Zero duty keeps it low; no runt pulse appears at the wrap.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pwm_o <= 1'b0;
		end else begin
			pwm_o <= {1'b0, pwm_cnt_reg} < pwm_duty_reg;
		end
	end

	// ************************************************************
	// Rotation count fall limiter
	// ************************************************************

	// Rises follow at once; falls are clipped per update so the motor keeps turning
	// The limit applies per target update, not per unit of time, so the
	// fall rate follows how often the upstream loop presents targets.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			speed_reg <= '0;
		end else if (target_valid_i) begin
			if ((target_speed_i >= speed_reg) || (cfg_reg.speed_fall_limit_sel == 3'h0)) begin
				speed_reg <= target_speed_i;
			end else if ((speed_reg - target_speed_i) >
				fall_limit(cfg_reg.speed_fall_limit_sel)) begin
				speed_reg <= speed_reg - fall_limit(cfg_reg.speed_fall_limit_sel);
			end else begin
				speed_reg <= target_speed_i;
			end
		end
	end

	assign applied_speed_o = speed_reg;

endmodule

// >>> olsc_pkg.sv
/*
 * Package for the open-loop speed curve block: register indices, field
 * positions, reset values, timing counts and the packed carriers.
 * Assumes a 250 MHz core clock and a classic Wishbone register bus.
 */
package olsc_pkg;

	// ************************************************************
	// Register indices (byte address is four times the index)
	// ************************************************************
	localparam logic [5:0] IDX_NO_STOP_BIT_STOP  = 6'h02; // No-stop bit and stop field
	localparam logic [5:0] IDX_START        = 6'h03; // Start threshold
	localparam logic [5:0] IDX_INFLECT      = 6'h04; // Inflection duty
	localparam logic [5:0] IDX_MAX          = 6'h05; // Max threshold
	localparam logic [5:0] IDX_MIN_OUT      = 6'h06; // Minimum output level
	localparam logic [5:0] IDX_HYST         = 6'h07; // Max threshold hysteresis
	localparam logic [5:0] IDX_SLOPE1_LO    = 6'h08; // Slope one low byte
	localparam logic [5:0] IDX_SLOPE1_HI    = 6'h09; // Slope one high bits and modes
	localparam logic [5:0] IDX_SLOPE2_LO    = 6'h0a; // Slope two low byte
	localparam logic [5:0] IDX_SLOPE2_HI    = 6'h0b; // Slope two high bits, loop mode
	localparam logic [5:0] IDX_FALL_LIMIT   = 6'h12; // Speed fall limit select
	localparam logic [5:0] IDX_STATUS       = 6'h20; // Live curve state
	localparam logic [5:0] IDX_CMD_STATUS   = 6'h21; // Live command and applied speed

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int NO_STOP_BIT_BIT     = 7;  // No-stop bit in its register
	localparam int PASS_BIT       = 1;  // Above-max pass-through
	localparam int FSOFF_BIT      = 0;  // Full speed at command off
	localparam int LOOP_BIT       = 0;  // Loop mode select
	localparam int FALL_SEL_LSB   = 5;  // Fall limit select low bit
	localparam int SLOPE_HI_LSB   = 2;  // Slope high bits start here

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [7:0] CFG_RESET = 8'h00; // Every setting clears at reset

	// ************************************************************
	// Duty scale and output PWM timing
	// ************************************************************
	localparam logic [9:0]  DUTY_FULL      = 10'h200; // 100 % on a 1/512 scale
	localparam logic [9:0]  MAX_OFFSET     = 10'h101; // Max threshold offset, 257
	localparam int          CLK_HZ         = 250000000;
	localparam int          PWM_FREQ_HZ    = 23400;   // Output PWM rate
	localparam int          PWM_STEPS      = 512;     // 9-bit output resolution
	localparam int          PWM_STEP_CYC   = CLK_HZ / (PWM_FREQ_HZ * PWM_STEPS);

	// ************************************************************
	// Fall limit table, rpm per update
	// ************************************************************
	localparam logic [13:0] FALL_LIM_1 = 14'h0200; // 512
	localparam logic [13:0] FALL_LIM_2 = 14'h0898; // 2200
	localparam logic [13:0] FALL_LIM_3 = 14'h0ed8; // 3800
	localparam logic [13:0] FALL_LIM_4 = 14'h1518; // 5400
	localparam logic [13:0] FALL_LIM_5 = 14'h1b58; // 7000
	localparam logic [13:0] FALL_LIM_6 = 14'h2198; // 8600
	localparam logic [13:0] FALL_LIM_7 = 14'h2800; // 10240

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} olsc_wb_req_type;

	typedef struct packed {
		logic        no_stop_bit;
		logic [6:0]  stop_threshold;
		logic [7:0]  start_threshold;
		logic [7:0]  inflection_duty;
		logic [7:0]  max_threshold;
		logic [7:0]  min_output_level;
		logic [3:0]  max_threshold_hysteresis;
		logic [13:0] slope_one;
		logic        above_max_passthrough;
		logic        full_speed_at_off;
		logic [13:0] slope_two;
		logic        loop_mode_select;
		logic [2:0]  speed_fall_limit_sel;
	} olsc_cfg_type;

endpackage

// >>> olsc_chk.sv
/* Port checker for olsc_top.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
module olsc_chk #(
	parameter int CMD_W   = 9,
	parameter int SPEED_W = 14
) (
	input wire logic                      core_clk_i,
	input wire logic                      rst_i,
	input wire olsc_pkg::olsc_wb_req_type wb_req_i,
	input wire logic                      wb_ack_o,
	input wire logic [31:0]               wb_dat_o,
	input wire logic [CMD_W:0]            speed_command_i,
	input wire logic                      target_valid_i,
	input wire logic [SPEED_W-1:0]        target_speed_i,
	input wire logic [SPEED_W-1:0]        applied_speed_o,
	input wire logic [9:0]                out_duty_o,
	input wire logic                      pwm_o,
	input wire logic                      open_loop_active_o
);
	// ****************
	// Properties
	// ****************
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	logic wr; // Bus write in flight
	assign wr = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we;
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	a_ack_answer: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
		else $error("no ack");
	a_duty_sat: assert property (out_duty_o <= 10'h200)
		else $error("duty over full");
	a_closed_zero: assert property (!open_loop_active_o [*2] |-> out_duty_o == 10'h000)
		else $error("closed loop duty");
	a_mode_stable: assert property (!wr |=> $stable(open_loop_active_o))
		else $error("mode moved");
	a_rise_copy: assert property (target_valid_i && target_speed_i >= applied_speed_o
		|=> applied_speed_o == $past(target_speed_i)) else $error("rise not copied");
	a_fall_bound: assert property (target_valid_i && target_speed_i < applied_speed_o
		|=> applied_speed_o >= $past(target_speed_i) && applied_speed_o < $past(applied_speed_o))
		else $error("fall out of range");
	a_speed_hold: assert property (!target_valid_i |=> $stable(applied_speed_o))
		else $error("speed moved");
	a_duty_static: assert property (($stable(speed_command_i) && !wr) [*3]
		|=> $stable(out_duty_o)) else $error("duty moved");
	c_fall: cover property (target_valid_i && target_speed_i < applied_speed_o);
	c_full: cover property (out_duty_o == 10'h200);
	c_pwm: cover property ($rose(pwm_o));
endmodule

// >>> olsc_cmd_src.sv
/* Speed command source model.
   Assumes the level is already quantised on the 1/512 scale. */
`timescale 1ns/1ps
module olsc_cmd_src (
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	input  wire logic [9:0] level_i,
	output logic      [9:0] cmd_o
);
	// ****************
	// Command register
	// ****************
	// Clip to full scale, as a real source cannot exceed 100 %
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cmd_o <= 10'h000;
		end else begin
			cmd_o <= level_i[9] ? 10'h200 : level_i;
		end
	end
endmodule

// >>> olsc_top_tb.sv
/* Self-checking bench for olsc_top.
   Assumes a 250 MHz clock and one-cycle Wishbone answers. */
`timescale 1ns/1ps
module olsc_top_tb;
	// ****************
	// Signals
	// ****************
	logic                      core_clk_i     = 1'b0;
	logic                      rst_i          = 1'b1;
	olsc_pkg::olsc_wb_req_type wb_req_i       = '0;
	logic                      target_valid_i = 1'b0;
	logic [13:0]               target_speed_i = 14'h0000;
	logic [9:0]                level          = 10'h000; // Requested command
	logic [9:0]                speed_command_i;
	logic                      wb_ack_o;
	logic [31:0]               wb_dat_o;
	logic [31:0]               rd;
	logic [13:0]               applied_speed_o;
	logic [9:0]                out_duty_o;
	logic                      pwm_o;
	logic                      open_loop_active_o;
	logic [31:0]               lfsr = 32'h000170f4; // Fixed seed
	logic [9:0]                c;
	int                        n_errors = 0;
	int                        total_checks = 0;
	logic [13:0] lim [8] = '{14'h0000, 14'h0200, 14'h0898, 14'h0ed8,
		14'h1518, 14'h1b58, 14'h2198, 14'h2800}; // Fall steps
	logic [5:0]  cfg_a [7] = '{6'h02, 6'h03, 6'h05, 6'h06, 6'h07, 6'h09, 6'h0b};
	logic [7:0]  cfg_d [7] = '{8'h2e, 8'h66, 8'hcc, 8'h33, 8'h01, 8'h10, 8'h01};
	always #2 core_clk_i = ~core_clk_i;
	olsc_cmd_src src (.core_clk_i(core_clk_i), .rst_i(rst_i), .level_i(level),
		.cmd_o(speed_command_i));
	olsc_top dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
		.wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .speed_command_i(speed_command_i),
		.target_valid_i(target_valid_i), .target_speed_i(target_speed_i),
		.applied_speed_o(applied_speed_o), .out_duty_o(out_duty_o), .pwm_o(pwm_o),
		.open_loop_active_o(open_loop_active_o));
	// ****************
	// Helpers
	// ****************
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Curve with start 102, min 51; gain is the slope over 1024
	function automatic logic [9:0] exp_curve(input logic [9:0] v, input int gain);
		int e;
		e = 51 + (int'(v) - 102) * gain;
		return (e > 512) ? 10'h200 : 10'(e);
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task automatic wb(input logic we, input logic [5:0] idx, input logic [7:0] d);
		@(posedge core_clk_i);
		wb_req_i <= {1'b1, 1'b1, we, idx, 2'b00, 4'hf, 24'h000000, d};
		do @(posedge core_clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_req_i <= '0;
	endtask
	// Present a command and compare the settled duty
	task automatic step(input logic [9:0] v, input logic [9:0] e);
		@(posedge core_clk_i);
		level <= v;
		repeat (5) @(posedge core_clk_i);
		chk("out_duty_o", {22'h000000, e}, {22'h000000, out_duty_o});
	endtask
	task automatic tgt(input logic [13:0] v, input logic [13:0] e);
		@(posedge core_clk_i);
		target_valid_i <= 1'b1;
		target_speed_i <= v;
		@(posedge core_clk_i);
		target_valid_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		chk("applied_speed_o", {18'h00000, e}, {18'h00000, applied_speed_o});
	endtask
	// Count pwm_o high cycles over one output period once the duty has settled
	task automatic pwm_chk(input logic [9:0] e);
		int h;
		h = 0;
		repeat (olsc_pkg::PWM_STEPS * olsc_pkg::PWM_STEP_CYC + 4) @(posedge core_clk_i);
		repeat (olsc_pkg::PWM_STEPS * olsc_pkg::PWM_STEP_CYC) begin
			@(posedge core_clk_i);
			if (pwm_o === 1'b1) h++;
		end
		chk("pwm_o", 32'(e) * 32'(olsc_pkg::PWM_STEP_CYC), 32'(h));
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// ****************
	// Sequence
	// ****************
	initial begin
		#200000;
		n_errors++;
		test_done();
	end
	initial begin
		repeat (10) @(posedge core_clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 6'h05, 8'h00);
		chk("max_threshold", 32'h00000000, rd);
		for (int i = 0; i < 7; i++) wb(1'b1, cfg_a[i], cfg_d[i]);
		wb(1'b0, 6'h03, 8'h00);
		chk("start_threshold", 32'h00000066, rd);
		wb(1'b0, 6'h3f, 8'h00);
		chk("unmapped", 32'h00000000, rd);
		step(10'h064, 10'h000);
		step(10'h0c8, 10'h095);
		pwm_chk(10'h095);
		for (int i = 0; i < 8; i++) begin
			lfsr = lfsr_next(lfsr);
			c = 10'(103 + lfsr % 353);
			step(c, exp_curve(c, 1));
		end
		step(10'h064, 10'h033);
		step(10'h032, 10'h000);
		step(10'h064, 10'h000);
		step(10'h000, 10'h000);
		wb(1'b1, 6'h09, 8'h11);
		step(10'h000, 10'h19a);
		step(10'h032, 10'h000);
		wb(1'b1, 6'h02, 8'hae);
		step(10'h032, 10'h19a);
		wb(1'b1, 6'h09, 8'h10);
		step(10'h032, 10'h033);
		step(10'h000, 10'h033);
		wb(1'b1, 6'h09, 8'h12);
		step(10'h1d6, 10'h1d6);
		step(10'h1cb, 10'h1cb);
		step(10'h1c7, 10'h194);
		wb(1'b1, 6'h09, 8'h13);
		step(10'h000, 10'h200);
		wb(1'b1, 6'h04, 8'h80);
		wb(1'b1, 6'h0b, 8'h21);
		step(10'h12c, 10'h125);
		step(10'h1e0, 10'h1e0);
		wb(1'b1, 6'h04, 8'h00);
		wb(1'b1, 6'h09, 8'h43);
		step(10'h12c, exp_curve(10'h12c, 4));
		wb(1'b1, 6'h0b, 8'h00);
		step(10'h12c, 10'h000);
		for (int s = 0; s < 8; s++) begin
			wb(1'b1, 6'h12, {3'(s), 5'h00});
			tgt(14'h2ee0, 14'h2ee0);
			tgt(14'h03e8, (s == 0) ? 14'h03e8 : 14'h2ee0 - lim[s]);
		end
		test_done();
	end
endmodule
bind olsc_top olsc_chk #(.CMD_W(CMD_W), .SPEED_W(SPEED_W)) chk_i (.core_clk_i(core_clk_i),
	.rst_i(rst_i), .wb_req_i(wb_req_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
	.speed_command_i(speed_command_i), .target_valid_i(target_valid_i),
	.target_speed_i(target_speed_i), .applied_speed_o(applied_speed_o),
	.out_duty_o(out_duty_o), .pwm_o(pwm_o), .open_loop_active_o(open_loop_active_o));
